//--- dv/counter_set_monitor.sv
// port checker for the counter set, bound to its top module
`timescale 1ns/100ps
`include "counter_set_consts.svh"
module counter_set_monitor #(
  parameter int ADDR_WIDTH = 12
) (
  input logic SYS_CLK_I,
  input logic RST_N_I,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic PWRITE_I,
  input logic [ADDR_WIDTH-1:0] PADDR_I,
  input counter_set_pkg::word_t PWDATA_I,
  input logic PREADY_O,
  input counter_set_pkg::nibble_t BIN_Q_O,
  input counter_set_pkg::nibble_t JOHNSON_Q_O,
  input counter_set_pkg::nibble_t GRAY_Q_O,
  input counter_set_pkg::nibble_t LOAD_Q_O,
  input logic LOAD_OE_O,
  input counter_set_pkg::nibble_t UPDN_Q_O,
  input counter_set_pkg::byte_t WIDE_Q_O
);
  import counter_set_pkg::*;
  // ==========================================================
  // shadow of the control and load data registers
  logic [5:0] ctrl;
  byte_t ldata;
  logic [1:0] calm;
  logic wr;
  logic quiet;
  assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  // controls reach the pins two edges after a write, so wait three
  assign quiet = calm == 2'h3;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= '0;
      ldata <= '0;
    end else if (wr && PADDR_I == ADDR_WIDTH'(`CTRL_OFS)) begin
      ctrl <= PWDATA_I[5:0];
    end else if (wr && PADDR_I == ADDR_WIDTH'(`LOAD_DATA_OFS)) begin
      ldata <= PWDATA_I[7:0];
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      calm <= '0;
    end else if (wr) begin
      calm <= '0;
    end else if (!quiet) begin
      calm <= calm + 2'h1;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_bin_step: assert property (quiet && !ctrl[0] |=> BIN_Q_O == $past(BIN_Q_O) + 4'h1)
    else $error("binary step wrong");
  a_clear_zero: assert property (quiet && ctrl[0] |-> BIN_Q_O == 4'h0 && JOHNSON_Q_O == 4'h0)
    else $error("clear not held");
  a_ring_shift: assert property (quiet && !ctrl[0] |=>
    JOHNSON_Q_O == {$past(JOHNSON_Q_O[2:0]), !$past(JOHNSON_Q_O[3])})
    else $error("ring shift wrong");
  a_gray_single: assert property (quiet && !ctrl[0] |=> $countones(GRAY_Q_O ^ $past(GRAY_Q_O)) == 1)
    else $error("gray step wrong");
  a_wide_step: assert property (quiet && !ctrl[5] |=> WIDE_Q_O == $past(WIDE_Q_O) + 8'h01)
    else $error("wide step wrong");
  a_wide_clear: assert property (quiet && ctrl[5] |-> WIDE_Q_O == 8'h00)
    else $error("wide clear wrong");
  a_load_wins: assert property (quiet && ctrl[1] |-> LOAD_Q_O == ldata[3:0] && UPDN_Q_O == ldata[7:4])
    else $error("load value wrong");
  a_count_hold: assert property (quiet && ctrl[2:1] == 2'h0 |=> $stable(LOAD_Q_O) && $stable(UPDN_Q_O))
    else $error("hold broken");
  a_count_dir: assert property (quiet && ctrl[2:1] == 2'h2 |=> LOAD_Q_O == $past(LOAD_Q_O) + 4'h1 &&
    UPDN_Q_O == ($past(ctrl[3]) ? $past(UPDN_Q_O) + 4'h1 : $past(UPDN_Q_O) - 4'h1))
    else $error("count step wrong");
  a_drive_en: assert property (quiet |-> LOAD_OE_O == ctrl[4])
    else $error("drive enable wrong");
endmodule
bind multi_style_counter_set counter_set_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_counter_set_monitor (
  .SYS_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O,
  .BIN_Q_O, .JOHNSON_Q_O, .GRAY_Q_O, .LOAD_Q_O, .LOAD_OE_O, .UPDN_Q_O, .WIDE_Q_O
);

//--- dv/multi_style_counter_set_test.sv
// self-checking bench for the counter set
`timescale 1ns/100ps
`include "counter_set_consts.svh"
module multi_style_counter_set_test;
  import counter_set_pkg::*;
  // ==========================================================
  // signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  word_t pwdata = 32'h0000_0000;
  word_t prdata, rd;
  logic pready, pslverr, load_oe, err;
  nibble_t bin_q, ring_q, gray_q, load_q, updn_q, prev;
  byte_t wide_q;
  int fail_count = 0;
  int comparisons = 0;
  nibble_t ring_seq [8] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
  always #2 sys_clk = ~sys_clk;
  multi_style_counter_set #(.ADDR_WIDTH(12)) i_multi_style_counter_set (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .BIN_Q_O(bin_q), .JOHNSON_Q_O(ring_q), .GRAY_Q_O(gray_q), .LOAD_Q_O(load_q), .LOAD_OE_O(load_oe),
    .UPDN_Q_O(updn_q), .WIDE_Q_O(wide_q)
  );
  // ==========================================================
  // tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    fail_count++;
    wrap_up();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input word_t d, output word_t q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        give_up();
      end
      @(posedge sys_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic write_reg(input logic [11:0] a, input word_t d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic read_check(input logic [11:0] a, input word_t exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, exp);
    check(word_t'(err), word_t'(exp_err));
  endtask
  // counters move every edge, so a bounded wait finds the first step
  task automatic wait_change(input int sel, input nibble_t v);
    int n;
    n = 0;
    while ((sel == 0 ? bin_q : sel == 1 ? load_q : updn_q) === v) begin
      n++;
      if (n > 16) begin
        give_up();
      end
      @(posedge sys_clk);
    end
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    read_check(`LOAD_DATA_OFS, 32'h0000_0000, 1'b0);
    write_reg(12'h010, 32'hFFFF_FFFF);
    read_check(12'h010, 32'h0000_0000, 1'b1);
    read_check(`CTRL_OFS, 32'h0000_0000, 1'b0);
    write_reg(`CTRL_OFS, 32'h0000_0021);
    read_check(`STATUS_OFS, 32'h0000_0000, 1'b0);
    read_check(`WIDE_OFS, 32'h0000_0000, 1'b0);
    write_reg(`CTRL_OFS, 32'h0000_0000);
    prev = 4'h0;
    wait_change(0, 4'h0);
    for (int i = 0; i < 260; i++) begin
      check(bin_q, nibble_t'(i + 1));
      check(ring_q, ring_seq[i % 8]);
      check(wide_q, byte_t'(i + 1));
      check($countones(gray_q ^ prev), 32'h0000_0001);
      prev = gray_q;
      @(posedge sys_clk);
    end
    write_reg(`LOAD_DATA_OFS, 32'h0000_000F);
    write_reg(`CTRL_OFS, 32'h0000_0016);
    apb(1'b0, `STATUS_OFS, 32'h0000_0000, rd, err);
    check(rd[19:12], 8'h0F);
    check(load_oe, 1'b1);
    write_reg(`CTRL_OFS, 32'h0000_0014);
    wait_change(1, 4'hF);
    for (int i = 0; i < 4; i++) begin
      check(load_q, i);
      check(updn_q, 15 - i);
      @(posedge sys_clk);
    end
    write_reg(`CTRL_OFS, 32'h0000_0008);
    repeat (3) @(posedge sys_clk);
    prev = updn_q;
    rd = word_t'(load_q);
    repeat (4) @(posedge sys_clk);
    check(updn_q, prev);
    check(load_q, rd);
    check(load_oe, 1'b0);
    write_reg(`CTRL_OFS, 32'h0000_000C);
    wait_change(2, prev);
    for (int i = 1; i < 5; i++) begin
      check(updn_q, nibble_t'(prev + i));
      @(posedge sys_clk);
    end
    wrap_up();
  end
endmodule

//--- rtl/counter_set_consts.svh
// register map, field positions and reset values of the counter set
`ifndef COUNTER_SET_CONSTS_SVH
`define COUNTER_SET_CONSTS_SVH

// ==========================================================
// register byte offsets
`define CTRL_OFS 12'h000
`define LOAD_DATA_OFS 12'h004
`define STATUS_OFS 12'h008
`define WIDE_OFS 12'h00C

// ==========================================================
// control register fields
`define CTRL_ASYNC_CLEAR 0
`define CTRL_LOAD_SELECT 1
`define CTRL_COUNT_EN 2
`define CTRL_COUNT_UP 3
`define CTRL_DRIVE_EN 4
`define CTRL_SYNC_CLEAR 5
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00

// ==========================================================
// load data fields (low nibble loadable, high nibble up/down)
`define LOAD_DATA_WIDTH 8
`define LOAD_DATA_RESET 8'h00

// ==========================================================
// status register fields
`define STATUS_BIN_LSB 0
`define STATUS_JOHNSON_LSB 4
`define STATUS_GRAY_LSB 8
`define STATUS_LOAD_LSB 12
`define STATUS_UPDN_LSB 16

// ==========================================================
// fixed values
`define NIBBLE_ZERO 4'h0
`define BYTE_ZERO 8'h00
`define WIDE_CLEAR 8'hF0
`define WORD_ZERO 32'h0000_0000

`endif

//--- rtl/counter_set_pkg.sv
// shared types of the counter set
package counter_set_pkg;

  typedef logic [3:0] nibble_t;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;

endpackage

//--- rtl/gray_link_if.sv
// link between the top and the gray code counter
`timescale 1ns/100ps
interface gray_link_if;
  import counter_set_pkg::*;

  logic clear;
  nibble_t code;

  modport counter (input clear, output code);
  modport owner (output clear, input code);
endinterface

//--- rtl/gray_step_counter.sv
// four-bit gray code counter, one bit changes per clock while clear is low
`timescale 1ns/100ps
`include "counter_set_consts.svh"
module gray_step_counter (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  gray_link_if.counter link
);
  import counter_set_pkg::*;

  nibble_t bin_now;
  nibble_t bin_next;
  nibble_t next_code;

  // ==========================================================
  // next state decode from registered feedback
  always_comb begin
    bin_now[3] = link.code[3];
    for (int i = 2; i >= 0; i--) begin
      bin_now[i] = bin_now[i + 1] ^ link.code[i];
    end
    bin_next = nibble_t'(bin_now + 4'h1);
    // binary to gray keeps a single bit flip per step
    next_code = bin_next ^ (bin_next >> 1);
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      link.code <= `NIBBLE_ZERO;
    end else if (link.clear) begin
      link.code <= `NIBBLE_ZERO;
    end else begin
      link.code <= next_code;
    end
  end

endmodule

//--- rtl/multi_style_counter_set.sv
// counter variants behind an apb register slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "counter_set_consts.svh"

// Summary of operation
// - lowest binary stage toggles each edge; clear acts without the clock
// - twisted ring: four chained stages, last stage inverted into the first
// - after clear, a high walks in over four clocks, then lows follow
// - twisted ring of n stages visits exactly 2n states, eight here
// - an upper binary bit holds until all lower bits are high, then toggles
// - each upper bit muxes its true or inverted copy, chosen by lower AND
// - gray counter changes exactly one bit per clock while the clear bit is low
// - load select high captures parallel data on the rising edge
// - load select low: count enable chooses increment or hold
// - loadable counter output drive enabled by the drive enable bit
// - up/down counter holds all bits while count enable and load select are both low
// - down toggles a bit when lower bits all low, up when all high
// - direction high counts up, low counts down, gating two product terms
// - eight-bit counter keeps bits 0-3 true and bits 4-7 inverted inside
// - synchronous clear loads low into 0-3, high into 4-7; outputs zero
// - outputs invert bits 4-7 and pass bits 0-3 for plain binary
// - toggle terms use complemented internal upper-nibble bits below the bit
module multi_style_counter_set #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_WIDTH-1:0] PADDR_I,
  input wire counter_set_pkg::word_t PWDATA_I,
  output counter_set_pkg::word_t PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output counter_set_pkg::nibble_t BIN_Q_O,
  output counter_set_pkg::nibble_t JOHNSON_Q_O,
  output counter_set_pkg::nibble_t GRAY_Q_O,
  output counter_set_pkg::nibble_t LOAD_Q_O,
  output logic LOAD_OE_O,
  output counter_set_pkg::nibble_t UPDN_Q_O,
  output counter_set_pkg::byte_t WIDE_Q_O
);
  import counter_set_pkg::*;

  // ==========================================================
  // declarations
  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [`LOAD_DATA_WIDTH-1:0] load_data;
  logic [11:0] addr;
  logic setup_phase;
  logic write_take;
  logic addr_hit;
  word_t next_rdata;

  logic async_clear;
  logic load_select;
  logic count_en;
  logic count_up;
  logic drive_en;
  logic sync_clear;
  nibble_t parallel_in;
  nibble_t updn_parallel_in;

  nibble_t bin_q;
  nibble_t bin_toggle;
  nibble_t johnson_q;
  nibble_t load_q;
  nibble_t updn_q;
  nibble_t updn_toggle;
  nibble_t updn_up_term;
  nibble_t updn_down_term;
  byte_t wide_iq;
  byte_t wide_toggle;
  byte_t wide_out;

  gray_link_if gray_link ();

  // ==========================================================
  // apb slave
  assign addr = 12'(PADDR_I);
  assign setup_phase = PSEL_I & ~PENABLE_I;
  // a write lands only at the edge where pready is sampled high
  assign write_take = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  always_comb begin
    addr_hit = 1'b1;
    next_rdata = `WORD_ZERO;
    if (addr == `CTRL_OFS) begin
      next_rdata = 32'(ctrl);
    end else if (addr == `LOAD_DATA_OFS) begin
      next_rdata = 32'(load_data);
    end else if (addr == `STATUS_OFS) begin
      next_rdata[`STATUS_BIN_LSB +: 4] = bin_q;
      next_rdata[`STATUS_JOHNSON_LSB +: 4] = johnson_q;
      next_rdata[`STATUS_GRAY_LSB +: 4] = gray_link.code;
      next_rdata[`STATUS_LOAD_LSB +: 4] = load_q;
      next_rdata[`STATUS_UPDN_LSB +: 4] = updn_q;
    end else if (addr == `WIDE_OFS) begin
      next_rdata = 32'(wide_out);
    end else begin
      addr_hit = 1'b0;
    end
  end

  // one wait-free access: ready follows the setup cycle
  // ready lasts a single cycle, so a master never sees a stale answer
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= setup_phase;
    end
  end

  // error travels with ready; unmapped writes are dropped by the decode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= setup_phase & ~addr_hit;
    end
  end

  // read data is captured at setup and held until the next read
  // status therefore shows the counters as they stood at the setup edge
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= `WORD_ZERO;
    end else if (setup_phase && !PWRITE_I) begin
      PRDATA_O <= next_rdata;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= `CTRL_RESET;
    end else if (write_take && addr == `CTRL_OFS) begin
      ctrl <= PWDATA_I[`CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      load_data <= `LOAD_DATA_RESET;
    end else if (write_take && addr == `LOAD_DATA_OFS) begin
      load_data <= PWDATA_I[`LOAD_DATA_WIDTH-1:0];
    end
  end

  // ==========================================================
  // control fields
  assign async_clear = ctrl[`CTRL_ASYNC_CLEAR];
  assign load_select = ctrl[`CTRL_LOAD_SELECT];
  assign count_en = ctrl[`CTRL_COUNT_EN];
  assign count_up = ctrl[`CTRL_COUNT_UP];
  assign drive_en = ctrl[`CTRL_DRIVE_EN];
  assign sync_clear = ctrl[`CTRL_SYNC_CLEAR];
  assign parallel_in = load_data[3:0];
  assign updn_parallel_in = load_data[7:4];

  // ==========================================================
  // free-running binary counter with direct clear
  // clear comes from a register bit, so it is glitch free
  assign bin_toggle[0] = 1'b1;
  for (genvar k = 1; k < 4; k++) begin : g_bin
    assign bin_toggle[k] = &bin_q[k-1:0];
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I or posedge async_clear) begin
    if (!RST_N_I) begin
      bin_q <= `NIBBLE_ZERO;
    end else if (async_clear) begin
      bin_q <= `NIBBLE_ZERO;
    end else begin
      for (int k = 0; k < 4; k++) begin
        // mux between inverted and true feedback
        bin_q[k] <= bin_toggle[k] ? ~bin_q[k] : bin_q[k];
      end
    end
  end

  // ==========================================================
  // twisted-ring counter
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I or posedge async_clear) begin
    if (!RST_N_I) begin
      johnson_q <= `NIBBLE_ZERO;
    end else if (async_clear) begin
      johnson_q <= `NIBBLE_ZERO;
    end else begin
      // eight states: 0,1,3,7,f,e,c,8
      johnson_q <= {johnson_q[2:0], ~johnson_q[3]};
    end
  end

  // ==========================================================
  // gray code counter
  assign gray_link.clear = async_clear;

  gray_step_counter i_gray_step_counter (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_N_I(RST_N_I),
    .link(gray_link.counter)
  );

  // ==========================================================
  // loadable counter with count and drive enable
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      load_q <= `NIBBLE_ZERO;
    end else if (load_select) begin
      load_q <= parallel_in;
    end else if (count_en) begin
      load_q <= nibble_t'(load_q + 4'h1);
    end
  end

  // ==========================================================
  // loadable up/down counter
  for (genvar k = 0; k < 4; k++) begin : g_updn
    if (k == 0) begin : g_lsb
      assign updn_up_term[k] = count_en & count_up;
      assign updn_down_term[k] = count_en & ~count_up;
    end else begin : g_upper
      // two product terms, one per direction
      assign updn_up_term[k] = count_en & count_up & (&updn_q[k-1:0]);
      assign updn_down_term[k] = count_en & ~count_up & ~(|updn_q[k-1:0]);
    end
    // count enable gates both terms, so a low enable holds every bit
    assign updn_toggle[k] = updn_up_term[k] | updn_down_term[k];
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      updn_q <= `NIBBLE_ZERO;
    end else if (load_select) begin
      updn_q <= updn_parallel_in;
    end else begin
      // toggle form wraps 0 <-> f on its own
      updn_q <= updn_q ^ updn_toggle;
    end
  end

  // ==========================================================
  // eight-bit counter with interlaced group polarity
  // grouping by nibble keeps each pin group one polarity
  for (genvar k = 0; k < 8; k++) begin : g_wide
    if (k == 0) begin : g_lsb
      assign wide_toggle[k] = 1'b1;
    end else if (k <= 4) begin : g_low_group
      assign wide_toggle[k] = &wide_iq[k-1:0];
    end else begin : g_high_group
      assign wide_toggle[k] = (&wide_iq[3:0]) & ~(|wide_iq[k-1:4]);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wide_iq <= `WIDE_CLEAR;
    end else if (sync_clear) begin
      wide_iq <= `WIDE_CLEAR;
    end else begin
      wide_iq <= wide_iq ^ wide_toggle;
    end
  end

  assign wide_out = {~wide_iq[7:4], wide_iq[3:0]};

  // ==========================================================
  // output registers
  // every pin lags its counter by one clock, traded for clean pin timing
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BIN_Q_O <= `NIBBLE_ZERO;
    end else begin
      BIN_Q_O <= bin_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      JOHNSON_Q_O <= `NIBBLE_ZERO;
    end else begin
      JOHNSON_Q_O <= johnson_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      GRAY_Q_O <= `NIBBLE_ZERO;
    end else begin
      GRAY_Q_O <= gray_link.code;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LOAD_Q_O <= `NIBBLE_ZERO;
    end else begin
      LOAD_Q_O <= load_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LOAD_OE_O <= 1'b0;
    end else begin
      // pin stays released while the enable is low
      LOAD_OE_O <= drive_en;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      UPDN_Q_O <= `NIBBLE_ZERO;
    end else begin
      UPDN_Q_O <= updn_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WIDE_Q_O <= `BYTE_ZERO;
    end else begin
      WIDE_Q_O <= wide_out;
    end
  end

endmodule
